// File: pkg/srsw_pkg.sv
package srsw_pkg;

  // Time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Watchdog setting in milliseconds
  localparam int WDT_MS_W = 11;
  localparam logic [WDT_MS_W-1:0] WDT_MS_MIN = 11'h00A;
  localparam logic [WDT_MS_W-1:0] WDT_MS_MAX = 11'h7D0;
  localparam logic [WDT_MS_W-1:0] WDT_MS_RST = 11'h0C8;
  localparam logic [WDT_MS_W-1:0] LED_FLASH_MS = 11'h0FA;

  // Input points, first to last
  localparam int NUM_POINTS = 32;
  localparam int SEL_W = 5;

  // Avalon byte offsets
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_WDT = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] REG_ERRCODE = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_INPUTS = 5'h10;

  // Control register fields
  localparam int CTRL_TOOL_STOP = 0;
  localparam int CTRL_ERR_CLR = 1;
  localparam int CTRL_CONTACT_EN = 2;
  localparam int CTRL_SEL_LSB = 8;
  localparam logic CTRL_TOOL_STOP_RST = 1'b0;
  localparam logic CTRL_CONTACT_EN_RST = 1'b0;
  localparam logic [SEL_W-1:0] CTRL_SEL_RST = 5'h00;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ERR = 2;
  localparam int STAT_LED = 3;
  localparam int STAT_FLAGS_LSB = 4;
  localparam int STAT_RUN_EN = 8;

  // Self-check error code for a watchdog timeout (arbitrary value)
  localparam logic [15:0] ERR_CODE_WDT = 16'h0016;
  localparam logic [15:0] ERR_CODE_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_STOPPING = 2'b11,
    ST_ERROR = 2'b10
  } srsw_state_t;

  typedef struct packed {
    logic run_after_first_scan_flag;
    logic initial_scan_pulse_flag;
    logic always_off_flag;
    logic always_on_flag;
  } srsw_flags_t;

  localparam srsw_flags_t FLAGS_RST = 4'h1;

endpackage : srsw_pkg

// File: rtl/srsw_top.sv
`timescale 1ns/1ps
module srsw_top
  import srsw_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int OUT_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic master_run_enable_i,
  input wire logic [NUM_POINTS-1:0] input_points_i,
  input wire logic scan_end_i,
  input wire logic [OUT_W-1:0] out_points_i,
  output logic [OUT_W-1:0] out_points_o,
  output logic scan_start_o,
  output logic scan_active_o,
  output srsw_flags_t special_flags_o,
  output logic self_check_error_flag_o,
  output logic [15:0] self_check_error_code_o,
  output logic run_led_o
);

  localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  // Pin synchronisers
  logic run_en_s1;
  logic run_en_s2;
  logic [NUM_POINTS-1:0] pts_s1;
  logic [NUM_POINTS-1:0] pts_s2;

  // Control registers
  logic tool_stop;
  logic contact_en;
  logic [SEL_W-1:0] contact_sel;
  logic [WDT_MS_W-1:0] wdt_ms;

  // Engine
  srsw_state_t state;
  srsw_state_t next_state;
  logic next_scan_start;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [WDT_MS_W-1:0] ms_cnt;
  logic [WDT_MS_W-1:0] flash_cnt;
  logic led_phase;

  // Bus decode
  logic req;
  logic wr_go;
  logic rd_take;
  logic err_clr;
  logic [31:0] rd_mux;
  logic [15:0] wdt_wr;
  logic [WDT_MS_W-1:0] wdt_new;

  // Derived requests
  logic contact_stop;
  logic remote_stop;
  logic go_run;
  logic scanning;
  logic wdt_expire;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_en_s1 <= 1'b0;
      run_en_s2 <= 1'b0;
      pts_s1 <= '0;
      pts_s2 <= '0;
    end else begin
      run_en_s1 <= master_run_enable_i;
      run_en_s2 <= run_en_s1;
      pts_s1 <= input_points_i;
      pts_s2 <= pts_s1;
    end
  end

  // Contact on asks for stop, off asks for run
  assign contact_stop = contact_en & pts_s2[contact_sel];
  assign remote_stop = contact_stop | tool_stop;
  // Remote sources only matter with master enable high
  assign go_run = run_en_s2 & ~remote_stop;
  assign scanning = (state == ST_RUN) || (state == ST_STOPPING);

  // Free running millisecond base, realigned at each scan start
  assign tick = (tick_cnt == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
    end else if (scan_start_o || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // A missed end within the setting is a timeout
  assign wdt_expire = scanning && !scan_end_i && (ms_cnt >= wdt_ms);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ms_cnt <= '0;
    end else if (scan_start_o) begin
      ms_cnt <= '0;
    end else if (scanning && tick && ms_cnt != WDT_MS_MAX) begin
      ms_cnt <= ms_cnt + 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_scan_start = 1'b0;
    case (state)
      ST_STOP: begin
        if (go_run) begin
          next_state = ST_RUN;
          next_scan_start = 1'b1;
        end
      end
      ST_RUN: begin
        if (!run_en_s2) begin
          next_state = ST_STOP;
        end else if (wdt_expire) begin
          next_state = ST_ERROR;
        end else if (remote_stop) begin
          next_state = scan_end_i ? ST_STOP : ST_STOPPING;
        end else if (scan_end_i) begin
          next_scan_start = 1'b1;
        end
      end
      ST_STOPPING: begin
        if (!run_en_s2) begin
          next_state = ST_STOP;
        end else if (wdt_expire) begin
          next_state = ST_ERROR;
        end else if (scan_end_i) begin
          next_state = ST_STOP;
        end
      end
      ST_ERROR: begin
        // Held until software acknowledges the error
        if (err_clr) begin
          next_state = ST_STOP;
        end
      end
      default: begin
        next_state = ST_STOP;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_STOP;
      scan_start_o <= 1'b0;
      scan_active_o <= 1'b0;
    end else begin
      state <= next_state;
      scan_start_o <= next_scan_start;
      scan_active_o <= (next_state == ST_RUN) || (next_state == ST_STOPPING);
    end
  end

  // Outputs gated on the edge that leaves run, so a timeout blanks them at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_points_o <= '0;
    end else if ((next_state == ST_RUN) || (next_state == ST_STOPPING)) begin
      out_points_o <= out_points_i;
    end else begin
      out_points_o <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      special_flags_o <= FLAGS_RST;
    end else begin
      special_flags_o.always_on_flag <= 1'b1;
      special_flags_o.always_off_flag <= 1'b0;
      if (next_state == ST_STOP) begin
        special_flags_o.initial_scan_pulse_flag <= 1'b0;
        special_flags_o.run_after_first_scan_flag <= 1'b0;
      end else if (state == ST_STOP && next_scan_start) begin
        special_flags_o.initial_scan_pulse_flag <= 1'b1;
      end else if (state == ST_RUN && next_state == ST_RUN && scan_end_i) begin
        special_flags_o.initial_scan_pulse_flag <= 1'b0;
        special_flags_o.run_after_first_scan_flag <= 1'b1;
      end
    end
  end

  // Error flag: a timeout in the clearing cycle keeps it set
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      self_check_error_flag_o <= 1'b0;
      self_check_error_code_o <= ERR_CODE_RST;
    end else if (wdt_expire && next_state == ST_ERROR) begin
      self_check_error_flag_o <= 1'b1;
      self_check_error_code_o <= ERR_CODE_WDT;
    end else if (err_clr && state == ST_ERROR) begin
      self_check_error_flag_o <= 1'b0;
    end
  end

  // Indicator: steady in run, flashing after a timeout, dark in stop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flash_cnt <= '0;
      led_phase <= 1'b0;
    end else if (state != ST_ERROR) begin
      flash_cnt <= '0;
      led_phase <= 1'b0;
    end else if (tick) begin
      if (flash_cnt == LED_FLASH_MS - 1'b1) begin
        flash_cnt <= '0;
        led_phase <= ~led_phase;
      end else begin
        flash_cnt <= flash_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_led_o <= 1'b0;
    end else begin
      case (next_state)
        ST_RUN: run_led_o <= 1'b1;
        ST_STOPPING: run_led_o <= 1'b1;
        ST_ERROR: run_led_o <= led_phase;
        default: run_led_o <= 1'b0;
      endcase
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  assign req = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~avs_waitrequest_o;
  assign rd_take = avs_read_i & avs_waitrequest_o;
  assign err_clr = wr_go && (avs_address_i == REG_CTRL) && avs_byteenable_i[0]
    && avs_writedata_i[CTRL_ERR_CLR];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tool_stop <= CTRL_TOOL_STOP_RST;
      contact_en <= CTRL_CONTACT_EN_RST;
      contact_sel <= CTRL_SEL_RST;
    end else if (wr_go && avs_address_i == REG_CTRL) begin
      if (avs_byteenable_i[0]) begin
        tool_stop <= avs_writedata_i[CTRL_TOOL_STOP];
        contact_en <= avs_writedata_i[CTRL_CONTACT_EN];
      end
      if (avs_byteenable_i[1]) begin
        contact_sel <= avs_writedata_i[CTRL_SEL_LSB +: SEL_W];
      end
    end
  end

  // Out-of-range settings are pulled to the nearest legal limit
  assign wdt_wr = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'(16'(wdt_ms) >> 8),
                   avs_byteenable_i[0] ? avs_writedata_i[7:0] : wdt_ms[7:0]};
  assign wdt_new = (wdt_wr < 16'(WDT_MS_MIN)) ? WDT_MS_MIN :
                   (wdt_wr > 16'(WDT_MS_MAX)) ? WDT_MS_MAX : wdt_wr[WDT_MS_W-1:0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wdt_ms <= WDT_MS_RST;
    end else if (wr_go && avs_address_i == REG_WDT && avs_byteenable_i[1:0] != 2'h0) begin
      wdt_ms <= wdt_new;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      REG_CTRL: begin
        rd_mux[CTRL_TOOL_STOP] = tool_stop;
        rd_mux[CTRL_CONTACT_EN] = contact_en;
        rd_mux[CTRL_SEL_LSB +: SEL_W] = contact_sel;
      end
      REG_WDT: rd_mux[WDT_MS_W-1:0] = wdt_ms;
      REG_STATUS: begin
        rd_mux[STAT_STATE_LSB +: 2] = state;
        rd_mux[STAT_ERR] = self_check_error_flag_o;
        rd_mux[STAT_LED] = run_led_o;
        rd_mux[STAT_FLAGS_LSB +: 4] = special_flags_o;
        rd_mux[STAT_RUN_EN] = run_en_s2;
      end
      REG_ERRCODE: rd_mux[15:0] = self_check_error_code_o;
      REG_INPUTS: rd_mux[NUM_POINTS-1:0] = pts_s2;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (rd_take) begin
      avs_readdata_o <= rd_mux;
    end
  end

endmodule : srsw_top

// File: bench/srsw_scan_model.sv
`timescale 1ns/1ps
module srsw_scan_model #(
  parameter int OUT_W = 16
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [7:0] len_i,
  input wire logic hang_i,
  output logic end_o,
  output logic [OUT_W-1:0] outs_o
);
  int cnt = -1;
  initial begin
    end_o = 1'b0;
    outs_o = '0;
  end
  // Hang mode withholds the end pulse to starve the watchdog
  always @(posedge clk_i) begin
    end_o <= 1'b0;
    if (start_i) begin
      cnt <= len_i;
      outs_o <= OUT_W'($urandom);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      cnt <= -1;
      end_o <= !hang_i;
    end
  end
endmodule : srsw_scan_model

// File: bench/srsw_top_asserts.sv
`timescale 1ns/1ps
module srsw_top_asserts
  import srsw_pkg::*;
#(
  parameter int OUT_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic master_run_enable_i,
  input wire logic scan_end_i,
  input wire logic [OUT_W-1:0] out_points_o,
  input wire logic scan_start_o,
  input wire logic scan_active_o,
  input wire srsw_flags_t special_flags_o,
  input wire logic self_check_error_flag_o,
  input wire logic [15:0] self_check_error_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic [2:0] low_cnt;
  // Margin of one edge over the synchroniser depth plus the state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || master_run_enable_i) low_cnt <= '0;
    else if (low_cnt != 3'h7) low_cnt <= low_cnt + 3'h1;
  end
  a_off_low: assert property (!special_flags_o.always_off_flag)
    else $error("always-off flag high");
  a_on_high: assert property (special_flags_o.always_on_flag)
    else $error("always-on flag low");
  a_stop_outs: assert property (!scan_active_o |-> out_points_o == '0)
    else $error("outputs on while stopped");
  a_init_rise: assert property ($rose(scan_active_o) |->
    special_flags_o.initial_scan_pulse_flag && scan_start_o) else $error("no initial pulse");
  a_init_end: assert property (scan_active_o && scan_end_i |=>
    !special_flags_o.initial_scan_pulse_flag &&
    special_flags_o.run_after_first_scan_flag == scan_active_o) else $error("flags at end");
  a_scan_loop: assert property (scan_active_o && scan_end_i |=>
    scan_start_o == scan_active_o) else $error("scan not restarted");
  a_flags_stop: assert property (!scan_active_o && !self_check_error_flag_o &&
    !$past(self_check_error_flag_o) |-> special_flags_o == 4'h1) else $error("flags in stop");
  a_enable_gate: assert property (low_cnt >= 3'h4 |-> !scan_active_o)
    else $error("running without enable");
  a_wdt_trip: assert property ($rose(self_check_error_flag_o) |->
    self_check_error_code_o == ERR_CODE_WDT && out_points_o == '0 && !scan_active_o)
    else $error("timeout handling wrong");
  c_trip: cover property ($rose(self_check_error_flag_o));
  c_loop: cover property (scan_active_o && scan_end_i);
  c_stop: cover property ($fell(scan_active_o) && !self_check_error_flag_o);
endmodule : srsw_top_asserts
bind srsw_top srsw_top_asserts #(.OUT_W(OUT_W)) srsw_top_asserts_inst (
  .clk_i, .sys_rst_i, .master_run_enable_i, .scan_end_i, .out_points_o, .scan_start_o,
  .scan_active_o, .special_flags_o, .self_check_error_flag_o, .self_check_error_code_o);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import srsw_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, rd = 1'b0, wr = 1'b0, men = 1'b0, hang = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rdat, q, pts = '0;
  logic [15:0] pin, pout, ecd;
  logic [7:0] len = 8'h08;
  logic wrq, send, sst, sact, efl, led, l0;
  srsw_flags_t flg;
  int err_total = 0, n_compared = 0, n, tog;
  int pt[3];
  srsw_top #(.TICK_CYC(10)) srsw_top_inst (.clk_i, .sys_rst_i, .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .master_run_enable_i(men),
    .input_points_i(pts), .scan_end_i(send), .out_points_i(pin), .out_points_o(pout),
    .scan_start_o(sst), .scan_active_o(sact), .special_flags_o(flg),
    .self_check_error_flag_o(efl), .self_check_error_code_o(ecd), .run_led_o(led));
  srsw_scan_model srsw_scan_model_inst (.clk_i, .start_i(sst), .len_i(len),
    .hang_i(hang), .end_o(send), .outs_o(pin));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Samples on the falling edge so registered outputs have settled
  task automatic till(ref logic s, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (s !== 1'b1 && k < lim);
    chk(s, 1'b1);
  endtask : till
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge clk_i);
      k++;
    end while (wrq !== 1'b0 && k < 20);
    if (k >= 20 && wrq !== 1'b0) begin
      err_total++;
      $display("Error %0t: bus access timed out", $time);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  initial begin
    #1500000;
    err_total++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h2F1F4BA1));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk(flg, FLAGS_RST);
    bus(1'b0, REG_WDT, '0);
    chk(q, WDT_MS_RST);
    bus(1'b0, 5'h14, '0);
    chk(q, '0);
    men <= 1'b1;
    till(sst, 20, n);
    chk(flg, 4'h5);
    repeat (2) @(negedge clk_i);
    chk(pout, pin);
    till(sst, 40, n);
    chk(flg, 4'h9);
    pt[0] = 0;
    pt[1] = 31;
    pt[2] = $urandom_range(1, 30);
    foreach (pt[i]) begin
      @(posedge clk_i);
      pts <= $urandom & ~(32'h1 << pt[i]);
      bus(1'b1, REG_CTRL, 32'h4 | (pt[i] << 8));
      till(sst, 40, n);
      @(posedge clk_i);
      pts[pt[i]] <= 1'b1;
      till(send, 40, n);
      chk(sact, 1'b1);
      @(negedge clk_i);
      chk({sact, pout, flg}, {1'b0, 16'h0, 4'h1});
      @(posedge clk_i);
      pts[pt[i]] <= 1'b0;
      till(sst, 20, n);
      chk(flg, 4'h5);
    end
    @(posedge clk_i);
    pts[pt[2]] <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h5 | (pt[2] << 8));
    pts[pt[2]] <= 1'b0;
    repeat (30) @(negedge clk_i);
    chk(sact, 1'b0);
    bus(1'b1, REG_CTRL, 32'h4 | (pt[2] << 8));
    till(sst, 20, n);
    @(posedge clk_i);
    men <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk({sact, pout}, '0);
    @(posedge clk_i);
    men <= 1'b1;
    bus(1'b1, REG_WDT, 32'h5);
    bus(1'b0, REG_WDT, '0);
    chk(q, WDT_MS_MIN);
    bus(1'b1, REG_WDT, 32'hBB8);
    bus(1'b0, REG_WDT, '0);
    chk(q, WDT_MS_MAX);
    bus(1'b1, REG_WDT, 32'hA);
    chk(efl, 1'b0);
    till(sst, 40, n);
    @(posedge clk_i);
    hang <= 1'b1;
    till(efl, 200, n);
    chk(n inside {[97:104]}, 1'b1);
    chk(sact, 1'b0);
    chk({pout, ecd}, {16'h0, ERR_CODE_WDT});
    bus(1'b0, REG_STATUS, '0);
    chk(q[2:0], 3'h6);
    tog = 0;
    l0 = led;
    repeat (5200) begin
      @(negedge clk_i);
      if (led !== l0) tog++;
      l0 = led;
    end
    chk(tog >= 2, 1'b1);
    @(posedge clk_i);
    hang <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h6 | (pt[2] << 8));
    till(sst, 20, n);
    chk({efl, ecd}, {1'b0, ERR_CODE_WDT});
    complete_run;
  end
endmodule : tb_top
